// File: verilog/p2s_stat_counters.sv
/*
  Port 2 MAC statistics counter bank: fourteen 32-bit read-only counters
  fed by one-cycle frame events, plus the receive gap threshold and
  length limits that steer the error checks.
  Assumes all event inputs come from MAC and switch logic on CORE_CLK,
  each event a one-cycle pulse with its qualifiers valid in that cycle,
  and a register reader on the same clock.
  Assumes REG_RD and REG_WR are one-cycle strobes that may share a cycle,
  and that a frame event lasts one cycle: a FRAME_DONE held high
  counts once for every cycle it stays high.
*/
// Behaviour
// RL1 - Count every received broadcast frame, good or errored.
// RL2 - Count every received multicast frame, good or errored.
// RL3 - Count every received unicast frame, good or errored.
// RL4 - Count received frames whose frame check sequence fails.
// RL5 - Count received frames with an alignment error.
// RL6 - Count received frames longer than upper or shorter than lower limit.
// RL7 - On early silicon the PHY error counter never moves.
// RL8 - PHY-corrupted frames are counted as frame check failures.
// RL9 - Count every transmitted frame.
// RL10 - Count transmitted broadcast frames.
// RL11 - Count transmitted multicast frames.
// RL12 - Count transmitted unicast frames.
// RL13 - Count received frames dropped for lack of destination queue room.
// RL14 - Early silicon: flooded frame counts as full drop only if both full.
// RL15 - Count received frames dropped by address filtering.
// RL16 - Count received frames with an interframe gap violation.
// RL17 - Gap not above threshold times 8 bit times drops frame, raises flag.
// RL18 - Length limits writable, defaults 0x618 upper and 0x40 lower.
// RL19 - Counters reset to zero, ignore writes, wrap, are not cleared by reads.
// RL20 - All-ones address broadcast, group bit multicast, else unicast.
`timescale 1ns/10ps
`default_nettype none
`include "p2s_map.svh"

module p2s_stat_counters
  import p2s_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Silicon revision level
  input wire logic EARLY_SILICON_REVISION,
  // Receive frame event
  input wire logic RX_FRAME_DONE,
  input wire logic [47:0] RX_DEST_ADDR,
  input wire logic [15:0] RX_FRAME_LENGTH,
  input wire logic [15:0] RX_GAP_BIT_TIMES,
  input wire logic RX_FCS_BAD,
  input wire logic RX_ALIGN_ERROR,
  input wire logic RX_PHY_ERROR,
  // Receive forwarding outcome
  input wire logic RX_TO_HOST,
  input wire logic RX_TO_OTHER_PORT,
  input wire logic RX_HOST_QUEUE_FULL,
  input wire logic RX_OTHER_QUEUE_FULL,
  input wire logic RX_FILTER_DROP,
  // Transmit frame event
  input wire logic TX_FRAME_DONE,
  input wire logic [47:0] TX_DEST_ADDR,
  // Register port
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_RD_VALID,
  // Gap check results
  output logic RX_GAP_ERROR_FLAG,
  output logic RX_GAP_DROP
);

  localparam int NUM_COUNTERS = `P2S_NUM_COUNTERS;

  // Counter slots in address order, base at the broadcast counter
  localparam logic [7:0] CNT_BASE = `P2S_RX_BCAST_OFF;
  localparam int IDX_RX_BCAST = 0;
  localparam int IDX_RX_MCAST = 1;
  localparam int IDX_RX_UCAST = 2;
  localparam int IDX_RX_FCS = 3;
  localparam int IDX_RX_ALIGN = 4;
  localparam int IDX_RX_LEN = 5;
  localparam int IDX_RX_PHY = 6;

  // Transmit counter slots
  localparam int IDX_TX_TOTAL = 7;
  localparam int IDX_TX_BCAST = 8;
  localparam int IDX_TX_MCAST = 9;
  localparam int IDX_TX_UCAST = 10;

  // Receive drop and gap counter slots
  localparam int IDX_RX_QFULL = 11;
  localparam int IDX_RX_FILT = 12;
  localparam int IDX_RX_GAP = 13;

  // Counter storage, one word per statistic
  p2s_count_t count_mem [NUM_COUNTERS];

  // Configuration steering the receive checks
  logic [`P2S_GAP_THR_W-1:0] rx_gap_threshold;
  logic [`P2S_LEN_W-1:0] rx_length_upper_limit;
  logic [`P2S_LEN_W-1:0] rx_length_lower_limit;

  // Receive destination class
  p2s_class_t rx_class;
  assign rx_class = p2s_classify(RX_DEST_ADDR); // RL20

  // Transmit destination class, same sorting as receive
  p2s_class_t tx_class;
  assign tx_class = p2s_classify(TX_DEST_ADDR); // RL20

  // Gap limit in bit times: threshold times eight, shifted in place
  wire [15:0] gap_limit_bits;
  assign gap_limit_bits = {7'h00, rx_gap_threshold, 3'b000}; // RL17

  // Gap verdict; equality is still a violation
  wire rx_gap_violation;
  assign rx_gap_violation = RX_GAP_BIT_TIMES <= gap_limit_bits; // RL17

  // Longer than the writable upper limit
  wire rx_too_long;
  assign rx_too_long = RX_FRAME_LENGTH > rx_length_upper_limit; // RL6

  // Shorter than the writable lower limit; both bounds are strict
  wire rx_too_short;
  assign rx_too_short = RX_FRAME_LENGTH < rx_length_lower_limit; // RL6

  // Flooded frame: both the host and the other port are destinations
  wire rx_flooded;
  assign rx_flooded = RX_TO_HOST & RX_TO_OTHER_PORT;

  // Any chosen destination without room loses the frame there
  wire rx_any_dest_full;
  assign rx_any_dest_full = (RX_TO_HOST & RX_HOST_QUEUE_FULL)
                          | (RX_TO_OTHER_PORT & RX_OTHER_QUEUE_FULL); // RL13

  // Both destinations without room
  wire rx_all_dest_full;
  assign rx_all_dest_full = RX_HOST_QUEUE_FULL & RX_OTHER_QUEUE_FULL;

  // Early silicon misses half-dropped flooded frames; later parts do not
  wire rx_queue_full_drop;
  assign rx_queue_full_drop = (EARLY_SILICON_REVISION & rx_flooded)
                            ? rx_all_dest_full   // RL14
                            : rx_any_dest_full;  // RL13

  // The reduced interface hides symbol errors on early silicon
  wire rx_phy_count_en;
  assign rx_phy_count_en = RX_PHY_ERROR & ~EARLY_SILICON_REVISION; // RL7

  // Per-counter increment strobes, one bit per counter slot
  wire [NUM_COUNTERS-1:0] count_inc;

  // Received broadcast frames, good or errored
  assign count_inc[IDX_RX_BCAST] = RX_FRAME_DONE
                                 & (rx_class == P2S_CLS_BROADCAST); // RL1

  // Received multicast frames, good or errored
  assign count_inc[IDX_RX_MCAST] = RX_FRAME_DONE
                                 & (rx_class == P2S_CLS_MULTICAST); // RL2

  // Received unicast frames, good or errored
  assign count_inc[IDX_RX_UCAST] = RX_FRAME_DONE
                                 & (rx_class == P2S_CLS_UNICAST); // RL3

  // Frame check failures; a PHY-corrupted frame fails its check too
  assign count_inc[IDX_RX_FCS] = RX_FRAME_DONE
                               & (RX_FCS_BAD | RX_PHY_ERROR); // RL4 RL8

  // Alignment errors
  assign count_inc[IDX_RX_ALIGN] = RX_FRAME_DONE & RX_ALIGN_ERROR; // RL5

  // Frames outside the length window
  assign count_inc[IDX_RX_LEN] = RX_FRAME_DONE
                               & (rx_too_long | rx_too_short); // RL6

  // PHY errors, only where the interface can report them
  assign count_inc[IDX_RX_PHY] = RX_FRAME_DONE & rx_phy_count_en; // RL7

  // Every transmitted frame
  assign count_inc[IDX_TX_TOTAL] = TX_FRAME_DONE; // RL9

  // Transmitted broadcast frames
  assign count_inc[IDX_TX_BCAST] = TX_FRAME_DONE
                                 & (tx_class == P2S_CLS_BROADCAST); // RL10

  // Transmitted multicast frames
  assign count_inc[IDX_TX_MCAST] = TX_FRAME_DONE
                                 & (tx_class == P2S_CLS_MULTICAST); // RL11

  // Transmitted unicast frames
  assign count_inc[IDX_TX_UCAST] = TX_FRAME_DONE
                                 & (tx_class == P2S_CLS_UNICAST); // RL12

  // Frames lost to a full destination queue
  assign count_inc[IDX_RX_QFULL] = RX_FRAME_DONE & rx_queue_full_drop; // RL13 RL14

  // Frames removed by the address filter
  assign count_inc[IDX_RX_FILT] = RX_FRAME_DONE & RX_FILTER_DROP; // RL15

  // Frames behind too short a gap; counted even though they are dropped
  assign count_inc[IDX_RX_GAP] = RX_FRAME_DONE & rx_gap_violation; // RL16

  // Counters: plain 32-bit adders wrap from all ones to zero
  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_count
    always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
        count_mem[i] <= `P2S_COUNT_RESET; // RL19
      end else if (count_inc[i]) begin
        count_mem[i] <= count_mem[i] + 32'h0000_0001; // RL19
      end
    end
  end

  // Counter window decode; the slot is the offset from the first counter
  wire [7:0] cnt_offset;
  wire cnt_hit;
  assign cnt_offset = REG_ADDR - CNT_BASE;
  assign cnt_hit = (REG_ADDR >= `P2S_RX_BCAST_OFF)
                 && (REG_ADDR <= `P2S_RX_GAP_OFF);

  // Configuration register decode
  wire gap_thr_hit;
  wire len_upper_hit;
  wire len_lower_hit;
  assign gap_thr_hit = REG_ADDR == `P2S_GAP_THR_OFF;
  assign len_upper_hit = REG_ADDR == `P2S_LEN_UPPER_OFF;
  assign len_lower_hit = REG_ADDR == `P2S_LEN_LOWER_OFF;

  // Counter word; slots past the last counter are never selected
  wire [3:0] cnt_index;
  wire [31:0] cnt_word;
  assign cnt_index = cnt_offset[3:0];
  assign cnt_word = cnt_hit ? count_mem[cnt_index] : 32'h0000_0000;

  // Read mux; unmapped addresses and reserved bits read zero
  wire [31:0] next_rdata;
  assign next_rdata = cnt_hit ? cnt_word
                    : gap_thr_hit ? {26'h000_0000, rx_gap_threshold}
                    : len_upper_hit ? {16'h0000, rx_length_upper_limit}
                    : len_lower_hit ? {16'h0000, rx_length_lower_limit}
                    : 32'h0000_0000;

  // Read answer one cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      REG_RD_VALID <= 1'b0;
    end else begin
      REG_RD_VALID <= REG_RD;
    end
  end

  // Read data holds until the next read; reads never disturb counts
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata; // RL19
    end
  end

  // Gap threshold; writes to counter addresses fall through
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_gap_threshold <= `P2S_GAP_THR_RESET;
    end else if (REG_WR && gap_thr_hit) begin
      rx_gap_threshold <= REG_WDATA[`P2S_GAP_THR_W-1:0]; // RL17
    end
  end

  // Upper length limit
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_length_upper_limit <= `P2S_LEN_UPPER_RESET; // RL18
    end else if (REG_WR && len_upper_hit) begin
      rx_length_upper_limit <= REG_WDATA[`P2S_LEN_W-1:0]; // RL18
    end
  end

  // Lower length limit
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rx_length_lower_limit <= `P2S_LEN_LOWER_RESET; // RL18
    end else if (REG_WR && len_lower_hit) begin
      rx_length_lower_limit <= REG_WDATA[`P2S_LEN_W-1:0]; // RL18
    end
  end

  // Gap drop pulse: one cycle for each offending frame
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RX_GAP_DROP <= 1'b0;
    end else begin
      RX_GAP_DROP <= RX_FRAME_DONE & rx_gap_violation; // RL17
    end
  end

  // Gap flag sticks until the next received frame gives its own verdict
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RX_GAP_ERROR_FLAG <= 1'b0;
    end else if (RX_FRAME_DONE) begin
      RX_GAP_ERROR_FLAG <= rx_gap_violation; // RL17
    end
  end

endmodule // p2s_stat_counters

`default_nettype wire

// File: verilog/p2s_map.svh
/*
  Offsets, reset values and field widths of the port 2 statistics bank.
  Included by the package users; holds definitions only.
*/
`ifndef P2S_MAP_SVH
`define P2S_MAP_SVH

// Counter offsets on the serial register port
`define P2S_RX_BCAST_OFF 8'hd1
`define P2S_RX_MCAST_OFF 8'hd2
`define P2S_RX_UCAST_OFF 8'hd3
`define P2S_RX_FCS_OFF 8'hd4
`define P2S_RX_ALIGN_OFF 8'hd5
`define P2S_RX_LEN_OFF 8'hd6
`define P2S_RX_PHY_OFF 8'hd7
`define P2S_TX_TOTAL_OFF 8'hd8
`define P2S_TX_BCAST_OFF 8'hd9
`define P2S_TX_MCAST_OFF 8'hda
`define P2S_TX_UCAST_OFF 8'hdb
`define P2S_RX_QFULL_OFF 8'hdc
`define P2S_RX_FILT_OFF 8'hdd
`define P2S_RX_GAP_OFF 8'hde

// Receive configuration registers steering the checks
`define P2S_GAP_THR_OFF 8'he5
`define P2S_LEN_UPPER_OFF 8'he6
`define P2S_LEN_LOWER_OFF 8'he7

// Reset values
`define P2S_COUNT_RESET 32'h0000_0000
`define P2S_GAP_THR_RESET 6'h0a
`define P2S_LEN_UPPER_RESET 16'h0618
`define P2S_LEN_LOWER_RESET 16'h0040

// Field widths and layout
`define P2S_GAP_THR_W 6
`define P2S_LEN_W 16
`define P2S_BIT_TIMES_PER_UNIT_SHIFT 3
`define P2S_NUM_COUNTERS 14

`endif

// File: verilog/p2s_pkg.sv
/*
  Types shared by the port 2 statistics bank.
  Assumes p2s_map.svh supplies the numeric constants.
*/
`default_nettype none

package p2s_pkg;

  // One 32-bit statistics word
  typedef logic [31:0] p2s_count_t;

  // Destination class of a frame, one-hot
  typedef enum logic [2:0] {
    P2S_CLS_UNICAST = 3'b001,
    P2S_CLS_MULTICAST = 3'b010,
    P2S_CLS_BROADCAST = 3'b100
  } p2s_class_t;

  // Sort a destination address into its class
  function automatic p2s_class_t p2s_classify(input logic [47:0] dest);
    p2s_class_t cls;
    cls = P2S_CLS_UNICAST;
    if (dest == 48'hffff_ffff_ffff) begin
      cls = P2S_CLS_BROADCAST;
    end else if (dest[40]) begin
      cls = P2S_CLS_MULTICAST;
    end
    return cls;
  endfunction

endpackage : p2s_pkg

`default_nettype wire

// File: tb/p2s_stat_chk.sv
/* Assertions on the statistics bank ports.
   Assumes CORE_CLK and RST_N of the bank; bound below. */
`timescale 1ns/10ps
`default_nettype none
`include "p2s_map.svh"
module p2s_stat_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Observed ports
  input wire logic RX_FRAME_DONE,
  input wire logic [15:0] RX_GAP_BIT_TIMES,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RD_VALID,
  input wire logic RX_GAP_ERROR_FLAG,
  input wire logic RX_GAP_DROP
);
  logic [5:0] thr;
  // Gap verdict and unmapped decode
  wire viol = RX_GAP_BIT_TIMES <= {7'h0, thr, 3'h0};
  wire hole = REG_ADDR < 8'hd1 || REG_ADDR > 8'he7 || (REG_ADDR > 8'hde && REG_ADDR < 8'he5);
  // Threshold shadow; a frame on the write edge is judged with the old threshold
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) thr <= `P2S_GAP_THR_RESET;
    else if (REG_WR && REG_ADDR == `P2S_GAP_THR_OFF) thr <= REG_WDATA[5:0];
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_ans; REG_RD |=> REG_RD_VALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_quiet; !REG_RD |=> !REG_RD_VALID && $stable(REG_RDATA); endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved");
  property p_rd_hole; REG_RD && hole |=> REG_RDATA == 32'h0; endproperty
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  property p_rd_thr; REG_RD && REG_ADDR == 8'he5 |=> REG_RDATA == {26'h0, $past(thr)}; endproperty
  a_rd_thr: assert property (p_rd_thr) else $error("threshold readback wrong");
  property p_gap_flag; RX_FRAME_DONE |=> RX_GAP_ERROR_FLAG == $past(viol); endproperty
  a_gap_flag: assert property (p_gap_flag) else $error("gap flag wrong");
  property p_gap_drop; RX_FRAME_DONE |=> RX_GAP_DROP == $past(viol); endproperty
  a_gap_drop: assert property (p_gap_drop) else $error("gap drop wrong");
  property p_no_drop; !RX_FRAME_DONE |=> !RX_GAP_DROP && $stable(RX_GAP_ERROR_FLAG); endproperty
  a_no_drop: assert property (p_no_drop) else $error("gap output without frame");
  property p_drop_flag; RX_GAP_DROP |-> RX_GAP_ERROR_FLAG; endproperty
  a_drop_flag: assert property (p_drop_flag) else $error("drop without flag");
  // Main scenarios reached
  c_hole: cover property (REG_RD && hole);
  c_drop: cover property (RX_GAP_DROP);
  c_wr: cover property (REG_WR && REG_ADDR == 8'he5);
endmodule // p2s_stat_chk
bind p2s_stat_counters p2s_stat_chk u_p2s_stat_chk (.CORE_CLK, .RST_N, .RX_FRAME_DONE,
  .RX_GAP_BIT_TIMES, .REG_RD, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RD_VALID,
  .RX_GAP_ERROR_FLAG, .RX_GAP_DROP);
`default_nettype wire

// File: tb/p2s_mac_model.sv
/* Frame event source standing in for the MAC and switch logic.
   Assumes the bench calls rx and tx; drives on falling edges. */
`timescale 1ns/10ps
`default_nettype none
module p2s_mac_model (
  // Clock
  input wire logic clk,
  // Events
  output logic rx_done,
  output logic [47:0] rx_dest,
  output logic [15:0] rx_len,
  output logic [15:0] rx_gap,
  output logic [7:0] rx_flags,
  output logic tx_done,
  output logic [47:0] tx_dest
);
  // Idle start
  initial begin
    {rx_done, rx_dest, rx_len, rx_gap, rx_flags, tx_done, tx_dest} = '0;
  end
  // One pulse; qualifiers turn to junk after it, never held
  task automatic rx(input logic [47:0] d, input logic [15:0] l, g, input logic [7:0] f);
    @(negedge clk);
    {rx_done, rx_dest, rx_len, rx_gap, rx_flags} = {1'b1, d, l, g, f};
    @(negedge clk);
    {rx_done, rx_dest, rx_len, rx_gap, rx_flags} = {1'b0, ~d, ~l, ~g, ~f};
  endtask
  task automatic tx(input logic [47:0] d);
    @(negedge clk);
    {tx_done, tx_dest} = {1'b1, d};
    @(negedge clk);
    {tx_done, tx_dest} = {1'b0, ~d};
  endtask
endmodule // p2s_mac_model
`default_nettype wire

// File: tb/test_port2_mac_statistics_counters.sv
/* Self-checking bench for the port 2 statistics bank.
   Assumes the bank, its checker bind and the frame model. */
`timescale 1ns/10ps
`default_nettype none
module test_port2_mac_statistics_counters
  import p2s_pkg::*;
;
  logic CORE_CLK = 0, RST_N = 0, early = 0, rd_s = 0, wr_s = 0;
  logic [7:0] ad = 0;
  logic [31:0] wd = 0;
  logic [15:0] up = 16'h618, lo = 16'h40;
  logic [5:0] thr = 6'h0a;
  wire [31:0] rdata;
  wire rvalid, rxd, txd, gflag, gdrop;
  wire [47:0] rda, tda;
  wire [15:0] rl, rg;
  wire [7:0] rf;
  int miscompares = 0, checked = 0, cyc = 0;
  p2s_count_t exp [14];
  // Clock and cycle ceiling
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict;
    end
  end
  p2s_mac_model u_p2s_mac_model (.clk(CORE_CLK), .rx_done(rxd), .rx_dest(rda), .rx_len(rl),
    .rx_gap(rg), .rx_flags(rf), .tx_done(txd), .tx_dest(tda));
  p2s_stat_counters u_p2s_stat_counters (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .EARLY_SILICON_REVISION(early), .RX_FRAME_DONE(rxd), .RX_DEST_ADDR(rda),
    .RX_FRAME_LENGTH(rl), .RX_GAP_BIT_TIMES(rg), .RX_FCS_BAD(rf[0]), .RX_ALIGN_ERROR(rf[1]),
    .RX_PHY_ERROR(rf[2]), .RX_TO_HOST(rf[3]), .RX_TO_OTHER_PORT(rf[4]),
    .RX_HOST_QUEUE_FULL(rf[5]), .RX_OTHER_QUEUE_FULL(rf[6]), .RX_FILTER_DROP(rf[7]),
    .TX_FRAME_DONE(txd), .TX_DEST_ADDR(tda), .REG_RD(rd_s), .REG_WR(wr_s), .REG_ADDR(ad),
    .REG_WDATA(wd), .REG_RDATA(rdata), .REG_RD_VALID(rvalid), .RX_GAP_ERROR_FLAG(gflag),
    .RX_GAP_DROP(gdrop));
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Register port: answer lands on the taking edge, checked at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge CORE_CLK);
    {rd_s, ad} = {1'b1, a};
    @(negedge CORE_CLK);
    rd_s = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge CORE_CLK);
    {wr_s, ad, wd} = {1'b1, a, d};
    @(negedge CORE_CLK);
    wr_s = 1'b0;
  endtask
  task automatic sweep;
    for (int i = 0; i < 14; i++) rd(8'hd1 + 8'(i), exp[i]);
  endtask
  function automatic int cls(input logic [47:0] d);
    return (d == '1) ? 0 : d[40] ? 1 : 2;
  endfunction
  // Expected counts worked out per frame
  task automatic frx(input logic [47:0] d, input logic [15:0] l, g, input logic [7:0] f);
    logic gv;
    gv = g <= {7'h0, thr, 3'h0};
    u_p2s_mac_model.rx(d, l, g, f);
    chk({30'h0, gflag, gdrop}, {30'h0, gv, gv});
    exp[cls(d)]++;
    if (f[0] || f[2]) exp[3]++;
    if (f[1]) exp[4]++;
    if (l > up || l < lo) exp[5]++;
    if (f[2] && !early) exp[6]++;
    if (((f[3] && f[5]) || (f[4] && f[6]))
        && (!(early && f[3] && f[4]) || (f[5] && f[6]))) exp[11]++;
    if (f[7]) exp[12]++;
    if (gv) exp[13]++;
  endtask
  task automatic ftx(input logic [47:0] d);
    u_p2s_mac_model.tx(d);
    exp[7]++;
    exp[8 + cls(d)]++;
  endtask
  task automatic give_verdict;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    foreach (exp[i]) exp[i] = '0;
    repeat (10) @(negedge CORE_CLK);
    RST_N = 1'b1;
    sweep;
    rd(8'he5, 32'ha);
    rd(8'he6, 32'h618);
    rd(8'he7, 32'h40);
    rd(8'h00, 32'h0);
    wr(8'hd1, 32'h5);
    wr(8'he6, 32'h100);
    wr(8'he7, 32'h50);
    wr(8'he5, 32'h3);
    {up, lo, thr} = {16'h100, 16'h50, 6'h3};
    rd(8'he6, 32'h100);
    rd(8'he7, 32'h50);
    rd(8'he5, 32'h3);
    frx(48'hffff_ffff_ffff, 16'h100, 16'h18, 8'h01);
    frx(48'h0100_0000_0001, 16'h101, 16'h19, 8'h02);
    frx(48'h0200_0000_0001, 16'h4f, 16'h40, 8'h04);
    frx(48'h0200_0000_0002, 16'h50, 16'h40, 8'h38);
    frx(48'h0200_0000_0003, 16'h60, 16'h10, 8'h80);
    ftx(48'hffff_ffff_ffff);
    ftx(48'h0300_0000_0000);
    ftx(48'h0000_0000_0001);
    sweep;
    sweep;
    early = 1'b1;
    frx(48'h0200_0000_0004, 16'h60, 16'h40, 8'h04);
    frx(48'h0200_0000_0005, 16'h60, 16'h40, 8'h38);
    frx(48'h0200_0000_0006, 16'h60, 16'h40, 8'h78);
    sweep;
    // Second reset in mid-run: counts clear, limits return to defaults
    RST_N = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    RST_N = 1'b1;
    foreach (exp[i]) exp[i] = '0;
    {up, lo, thr} = {16'h618, 16'h40, 6'h0a};
    sweep;
    rd(8'he5, 32'ha);
    rd(8'he6, 32'h618);
    rd(8'he7, 32'h40);
    frx(48'hffff_ffff_ffff, 16'h40, 16'h50, 8'h00);
    sweep;
    give_verdict;
  end
endmodule // test_port2_mac_statistics_counters
`default_nettype wire
